// File: verilog/atm_pkg.sv
/*
  Package for the 16-bit interval timer: register offsets, control bit
  positions, prescale codes, write-transfer timing and shared types.
  Assumes an APB slave with 32-bit data and word-aligned registers.
*/
package atm_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CTRL_CLR = 8'h04;
  localparam logic [7:0] OFF_CTRL_SET = 8'h08;
  localparam logic [7:0] OFF_CTRL_INV = 8'h0c;
  localparam logic [7:0] OFF_COUNT = 8'h10;
  localparam logic [7:0] OFF_PERIOD = 8'h14;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h1c;
  localparam logic [7:0] OFF_MODE = 8'h20;
  // Control bit positions
  localparam int B_ON = 15;
  localparam int B_IDLE = 13;
  localparam int B_WBLK = 12;
  localparam int B_WPEND = 11;
  localparam int B_GATE = 7;
  localparam int B_PS_HI = 5;
  localparam int B_PS_LO = 4;
  localparam int B_SYNC = 2;
  localparam int B_SRC = 1;
  // Writable control bits; all others read zero except bit 11, which reads the pending flag
  localparam logic [31:0] CTRL_WMASK = 32'h0000_b0b6;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [15:0] PERIOD_RESET = 16'hffff;
  // Mode register bits: idle and sleep requests from the power manager
  localparam int B_MODE_IDLE = 0;
  localparam int B_MODE_SLEEP = 1;
  // Interrupt status bits
  localparam int B_IRQ_MATCH = 0;
  localparam int B_IRQ_WDONE = 1;
  // Prescale codes and their divide ratios
  localparam logic [1:0] PS_1 = 2'h0;
  localparam logic [1:0] PS_8 = 2'h1;
  localparam logic [1:0] PS_64 = 2'h2;
  localparam logic [1:0] PS_256 = 2'h3;
  localparam logic [7:0] DIV_8_M1 = 8'h07;
  localparam logic [7:0] DIV_64_M1 = 8'h3f;
  localparam logic [7:0] DIV_256_M1 = 8'hff;
  // Cycles an asynchronous count write takes to cross over
  localparam logic [2:0] WXFER_CYCLES = 3'h3;
  // Counting mode, decoded from the control bits
  typedef enum logic [1:0] {
    MODE_INT = 2'b00,
    MODE_GATED = 2'b01,
    MODE_EXT_SYNC = 2'b10,
    MODE_EXT_ASYNC = 2'b11
  } atm_mode_type;
  // APB request bundle
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [7:0] addr;
    logic [31:0] wdata;
  } atm_apb_req_type;
endpackage

// File: verilog/atm_timer.sv
/*
  Single 16-bit interval timer/counter with APB register access.
  Assumes ref_clk at 100 MHz, rst asynchronous active high, and external
  count/gate pins asynchronous to ref_clk (each passes two flip-flops).
*/
// The address map and register access over APB were decided locally.
`timescale 1ns/1ns
// Functional notes
// - One 16-bit counter, timer or event counter
// - Four modes: internal, gated, ext sync, ext async
// - Bit 15 enables timer, resets to zero
// - Bit 13 halts timer during idle
// - Write-block bit drops count writes while pending
// - Write-block clear accepts back-to-back count writes
// - Bit 11 shows async count write pending
// - Pending bit reads zero in synchronous modes
// - Bit 7 gates only with internal source
// - Prescale codes divide by 1, 8, 64, 256
// - Timer keeps counting in sleep, and in idle unless bit 13 is set
// - Async external mode counts pin edges sampled on ref_clk
// - Clear, set, invert alias registers for control
// - Unimplemented control bits ignore writes, read zero
// - Bit 1 selects external pin or peripheral clock
// - Bit 2 picks sync external; ignored internally
module atm_timer #(
  parameter int CNT_W = 16
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic externalCountInput,
  input wire logic gateInput,
  output logic timerIrq
);
  atm_pkg::atm_apb_req_type req;           // Bundled bus request
  logic [31:0] ctrl_reg;                   // Control register
  logic [CNT_W-1:0] count_reg;             // Count value
  logic [CNT_W-1:0] period_reg;            // Period value
  logic [1:0] irqStat_reg;                 // Sticky event flags
  logic [1:0] irqMask_reg;                 // Interrupt enables
  logic [1:0] mode_reg;                    // Idle/sleep inputs
  logic [7:0] pre_reg;                     // Prescale counter
  logic [2:0] wxfer_reg;                   // Async write transfer countdown
  logic [CNT_W-1:0] wdata_reg;             // Count value in flight
  logic extMeta_reg, extSync_reg, extDly_reg;  // External pin synchroniser
  logic gateMeta_reg, gateSync_reg;            // Gate pin synchroniser
  logic wrAcc, cntWrite, wPend, extRise, srcTick, preTick, run, hit;
  atm_pkg::atm_mode_type mode;
  logic [31:0] ctrlWr;

  assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};
  // Zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;
  assign wrAcc = req.sel && req.enable && req.write;

  // Decode a word offset as mapped
  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a == atm_pkg::OFF_CTRL) || (a == atm_pkg::OFF_CTRL_CLR) ||
               (a == atm_pkg::OFF_CTRL_SET) || (a == atm_pkg::OFF_CTRL_INV) ||
               (a == atm_pkg::OFF_COUNT) || (a == atm_pkg::OFF_PERIOD) ||
               (a == atm_pkg::OFF_IRQ_STAT) || (a == atm_pkg::OFF_IRQ_MASK) ||
               (a == atm_pkg::OFF_MODE);
  endfunction
  // Control register and its clear, set and invert aliases
  function automatic logic isCtrlAddr(input logic [7:0] a);
    isCtrlAddr = (a == atm_pkg::OFF_CTRL) || (a == atm_pkg::OFF_CTRL_CLR) ||
                 (a == atm_pkg::OFF_CTRL_SET) || (a == atm_pkg::OFF_CTRL_INV);
  endfunction
  // Unmapped addresses answer with an error
  assign pslverr = req.sel && req.enable && !isMapped(req.addr);

  // Mode decode from source and sync bits
  always_comb begin
    if (!ctrl_reg[atm_pkg::B_SRC]) begin
      // Internal source: sync bit ignored, gate bit honoured
      mode = ctrl_reg[atm_pkg::B_GATE] ? atm_pkg::MODE_GATED : atm_pkg::MODE_INT;
    end else begin
      // External source: gate ignored
      mode = ctrl_reg[atm_pkg::B_SYNC] ? atm_pkg::MODE_EXT_SYNC
                                       : atm_pkg::MODE_EXT_ASYNC;
    end
  end

  // Pending write only exists in async mode
  // Software polls this bit: the written value only reaches the count once the transfer ends
  assign wPend = (wxfer_reg != 3'h0) && (mode == atm_pkg::MODE_EXT_ASYNC);

  // Count write accepted unless blocked by a pending write
  assign cntWrite = wrAcc && (req.addr == atm_pkg::OFF_COUNT) &&
                    !(ctrl_reg[atm_pkg::B_WBLK] && wPend);

  // Control write with clear/set/invert aliases, masked
  always_comb begin
    ctrlWr = ctrl_reg;
    case (req.addr)
      atm_pkg::OFF_CTRL: ctrlWr = req.wdata;
      atm_pkg::OFF_CTRL_CLR: ctrlWr = ctrl_reg & ~req.wdata;
      atm_pkg::OFF_CTRL_SET: ctrlWr = ctrl_reg | req.wdata;
      atm_pkg::OFF_CTRL_INV: ctrlWr = ctrl_reg ^ req.wdata;
      default: ctrlWr = ctrl_reg;
    endcase
    ctrlWr = ctrlWr & atm_pkg::CTRL_WMASK;
  end

  // Control register, cleared at reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= atm_pkg::CTRL_RESET;
    end else if (wrAcc && isCtrlAddr(req.addr)) begin
      ctrl_reg <= ctrlWr;
    end
  end

  // Period, mask and mode registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      period_reg <= atm_pkg::PERIOD_RESET;
      irqMask_reg <= 2'h0;
      mode_reg <= 2'h0;
    end else if (wrAcc) begin
      if (req.addr == atm_pkg::OFF_PERIOD) begin
        period_reg <= req.wdata[CNT_W-1:0];
      end
      if (req.addr == atm_pkg::OFF_IRQ_MASK) begin
        irqMask_reg <= req.wdata[1:0];
      end
      if (req.addr == atm_pkg::OFF_MODE) begin
        mode_reg <= req.wdata[1:0];
      end
    end
  end

  // Two-flop synchronisers for the pins, then an edge detector
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      extMeta_reg <= 1'b0;
      extSync_reg <= 1'b0;
      extDly_reg <= 1'b0;
      gateMeta_reg <= 1'b0;
      gateSync_reg <= 1'b0;
    end else begin
      extMeta_reg <= externalCountInput;
      extSync_reg <= extMeta_reg;
      extDly_reg <= extSync_reg;
      gateMeta_reg <= gateInput;
      gateSync_reg <= gateMeta_reg;
    end
  end
  assign extRise = extSync_reg && !extDly_reg;

  // Run while enabled and not halted by idle; sleep never halts
  assign run = ctrl_reg[atm_pkg::B_ON] &&
               !(ctrl_reg[atm_pkg::B_IDLE] && mode_reg[atm_pkg::B_MODE_IDLE]);

  // Source tick: peripheral clock, gated clock, or external edge
  always_comb begin
    case (mode)
      atm_pkg::MODE_INT: srcTick = 1'b1;
      atm_pkg::MODE_GATED: srcTick = gateSync_reg;
      atm_pkg::MODE_EXT_SYNC: srcTick = extRise;
      atm_pkg::MODE_EXT_ASYNC: srcTick = extRise;
      default: srcTick = 1'b0;
    endcase
  end

  // Terminal value of the prescaler for the selected code
  function automatic logic [7:0] preLimit(input logic [1:0] ps);
    case (ps)
      atm_pkg::PS_8: preLimit = atm_pkg::DIV_8_M1;
      atm_pkg::PS_64: preLimit = atm_pkg::DIV_64_M1;
      atm_pkg::PS_256: preLimit = atm_pkg::DIV_256_M1;
      default: preLimit = 8'h00;
    endcase
  endfunction

  // Prescaler: one tick per 1/8/64/256 source ticks
  assign preTick = run && srcTick &&
    (pre_reg == preLimit(ctrl_reg[atm_pkg::B_PS_HI:atm_pkg::B_PS_LO]));
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pre_reg <= 8'h00;
    end else if (!run || cntWrite) begin
      pre_reg <= 8'h00;
    end else if (srcTick) begin
      pre_reg <= preTick ? 8'h00 : pre_reg + 8'h01;
    end
  end

  assign hit = preTick && (count_reg == period_reg);

  // Async transfer countdown; synchronous modes apply writes at once
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wxfer_reg <= 3'h0;
      wdata_reg <= '0;
    end else if (cntWrite && (mode == atm_pkg::MODE_EXT_ASYNC)) begin
      wxfer_reg <= atm_pkg::WXFER_CYCLES;
      wdata_reg <= req.wdata[CNT_W-1:0];
    end else if (wxfer_reg != 3'h0) begin
      wxfer_reg <= wxfer_reg - 3'h1;
    end
  end

  // Counter: writes load, period match wraps to zero
  // A finishing async write wins over a tick in the same cycle; that tick is lost
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count_reg <= '0;
    end else if (cntWrite && (mode != atm_pkg::MODE_EXT_ASYNC)) begin
      count_reg <= req.wdata[CNT_W-1:0];
    end else if (wxfer_reg == 3'h1) begin
      count_reg <= wdata_reg;
    end else if (hit) begin
      count_reg <= '0;
    end else if (preTick) begin
      count_reg <= count_reg + 1'b1;
    end
  end

  // Sticky flags: set wins over write-one-to-clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irqStat_reg <= 2'h0;
    end else begin
      irqStat_reg[atm_pkg::B_IRQ_MATCH] <= hit || (irqStat_reg[atm_pkg::B_IRQ_MATCH] &&
        !(wrAcc && req.addr == atm_pkg::OFF_IRQ_STAT && req.wdata[atm_pkg::B_IRQ_MATCH]));
      irqStat_reg[atm_pkg::B_IRQ_WDONE] <= (wxfer_reg == 3'h1) ||
        (irqStat_reg[atm_pkg::B_IRQ_WDONE] &&
        !(wrAcc && req.addr == atm_pkg::OFF_IRQ_STAT && req.wdata[atm_pkg::B_IRQ_WDONE]));
    end
  end
  assign timerIrq = |(irqStat_reg & irqMask_reg);

  // Read data, registered during the setup cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0;
    end else if (req.sel && !req.enable && !req.write) begin
      case (req.addr)
        atm_pkg::OFF_CTRL, atm_pkg::OFF_CTRL_CLR, atm_pkg::OFF_CTRL_SET,
        atm_pkg::OFF_CTRL_INV: begin
          prdata <= ctrl_reg | ({31'h0, wPend} << atm_pkg::B_WPEND);
        end
        atm_pkg::OFF_COUNT: prdata <= {{(32-CNT_W){1'b0}}, count_reg};
        atm_pkg::OFF_PERIOD: prdata <= {{(32-CNT_W){1'b0}}, period_reg};
        atm_pkg::OFF_IRQ_STAT: prdata <= {30'h0, irqStat_reg};
        atm_pkg::OFF_IRQ_MASK: prdata <= {30'h0, irqMask_reg};
        atm_pkg::OFF_MODE: prdata <= {30'h0, mode_reg};
        default: prdata <= 32'h0;
      endcase
    end
  end

  // Checks
  // Each assertion guards one rule; the covers show the main scenarios were reached
  a_pend_sync_zero: assert property (@(posedge ref_clk) disable iff (rst)
    (req.sel && !req.enable && !req.write && req.addr == atm_pkg::OFF_CTRL &&
     mode != atm_pkg::MODE_EXT_ASYNC) |=> !prdata[atm_pkg::B_WPEND])
    else $error("pending bit read in sync mode");
  a_block_write: assert property (@(posedge ref_clk) disable iff (rst)
    (wrAcc && req.addr == atm_pkg::OFF_COUNT && ctrl_reg[atm_pkg::B_WBLK] && wPend)
    |=> $stable(wxfer_reg) || (wxfer_reg == $past(wxfer_reg) - 3'h1))
    else $error("blocked count write restarted transfer");
  a_async_wr_done: assert property (@(posedge ref_clk) disable iff (rst)
    (cntWrite && mode == atm_pkg::MODE_EXT_ASYNC) ##1 (!cntWrite)[*3]
    |=> (count_reg == $past(req.wdata[CNT_W-1:0], 4)))
    else $error("async write not applied after its transfer");
  a_sync_wr_now: assert property (@(posedge ref_clk) disable iff (rst)
    (cntWrite && mode != atm_pkg::MODE_EXT_ASYNC) |=> count_reg == $past(req.wdata[15:0]))
    else $error("sync count write lost");
  a_off_holds: assert property (@(posedge ref_clk) disable iff (rst)
    (!ctrl_reg[atm_pkg::B_ON] && !cntWrite && wxfer_reg == 3'h0) |=> $stable(count_reg))
    else $error("counter moved while disabled");
  a_idle_halt: assert property (@(posedge ref_clk) disable iff (rst)
    (ctrl_reg[atm_pkg::B_IDLE] && mode_reg[atm_pkg::B_MODE_IDLE]) |-> !preTick)
    else $error("tick during idle halt");
  a_wrap_flag: assert property (@(posedge ref_clk) disable iff (rst)
    hit |=> (count_reg == '0 || $past(cntWrite) || $past(wxfer_reg) == 3'h1) &&
    irqStat_reg[atm_pkg::B_IRQ_MATCH]) else $error("period match not handled");
  a_div8: assert property (@(posedge ref_clk) disable iff (rst)
    (preTick && mode == atm_pkg::MODE_INT &&
     ctrl_reg[atm_pkg::B_PS_HI:atm_pkg::B_PS_LO] == atm_pkg::PS_8)
    ##1 (run && !cntWrite && mode == atm_pkg::MODE_INT &&
     ctrl_reg[atm_pkg::B_PS_HI:atm_pkg::B_PS_LO] == atm_pkg::PS_8)[*8] |-> preTick)
    else $error("divide by eight wrong");
  a_reserved_zero: assert property (@(posedge ref_clk) disable iff (rst)
    (ctrl_reg & ~atm_pkg::CTRL_WMASK) == 32'h0) else $error("reserved control bit set");
  c_wrap: cover property (@(posedge ref_clk) disable iff (rst) hit);
  c_async_wr: cover property (@(posedge ref_clk) disable iff (rst) wxfer_reg == 3'h1);
  c_gated: cover property (@(posedge ref_clk) disable iff (rst)
    preTick && mode == atm_pkg::MODE_GATED);
  c_blocked: cover property (@(posedge ref_clk) disable iff (rst)
    wrAcc && req.addr == atm_pkg::OFF_COUNT && !cntWrite);
  c_ext_async: cover property (@(posedge ref_clk) disable iff (rst)
    preTick && mode == atm_pkg::MODE_EXT_ASYNC);
endmodule

// File: testbench/test_atm_timer.sv
/*
  Self-checking bench for the 16-bit interval timer with APB registers.
  Assumes a zero-wait APB slave and three-cycle asynchronous count writes.
*/
`timescale 1ns/1ns
module test_atm_timer;
  logic ref_clk = 1'b0; // 100 MHz clock
  logic rst = 1'b1; // Reset, active high
  logic psel = 1'b0; // APB select
  logic penable = 1'b0; // APB enable
  logic pwrite = 1'b0; // APB direction
  logic [7:0] paddr = 8'h00; // APB address
  logic [31:0] pwdata = 32'h0; // APB write data
  logic [31:0] prdata; // APB read data
  logic pready; // APB ready
  logic pslverr; // APB error
  logic externalCountInput = 1'b0; // External count pin
  logic gateInput = 1'b0; // Gate pin
  logic timerIrq; // Interrupt output
  logic [31:0] rdVal; // Last read data
  logic errSeen; // Error flag of last transfer
  logic chain = 1'b0; // Last transfer kept psel high
  logic [31:0] v; // Scratch value
  int k; // Loop and pulse count
  int mismatches = 0; // Mismatches seen
  int checks = 0; // Comparisons made
  // Control bits as the rules place them
  localparam logic [31:0] ctlOn = 32'h1 << atm_pkg::B_ON;
  localparam logic [31:0] ctlIdle = 32'h1 << atm_pkg::B_IDLE;
  localparam logic [31:0] ctlBlk = 32'h1 << atm_pkg::B_WBLK;
  localparam logic [31:0] ctlPend = 32'h1 << atm_pkg::B_WPEND;
  localparam logic [31:0] ctlGate = 32'h1 << atm_pkg::B_GATE;
  localparam logic [31:0] ctlSync = 32'h1 << atm_pkg::B_SYNC;
  localparam logic [31:0] ctlSrc = 32'h1 << atm_pkg::B_SRC;
  localparam logic [31:0] implMask = 32'h0000_b0b6; // Bits 15,13,12,7,5,4,2,1

  atm_timer #(.CNT_W(16)) u_dut (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .externalCountInput(externalCountInput), .gateInput(gateInput), .timerIrq(timerIrq)
  );

  // Clock generator
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer; hold keeps psel up for a following setup
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd,
                     input bit hold);
    // Idle edge between separate transfers, so no access follows a disable at once
    if (!chain) @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    // Wait for ready however long it takes; only the watchdog ends a hang
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rdVal = prdata;
    errSeen = pslverr;
    penable <= 1'b0;
    if (!hold) psel <= 1'b0;
    chain = hold;
  endtask

  task automatic wrr(input logic [7:0] ad, input logic [31:0] wd, input bit hold = 1'b0);
    apb(1'b1, ad, wd, hold);
  endtask

  task automatic rd(input logic [7:0] ad);
    apb(1'b0, ad, 32'h0, 1'b0);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // One external rising edge, slow enough for the synchroniser
  task automatic pulse();
    externalCountInput <= 1'b1;
    cyc(4);
    externalCountInput <= 1'b0;
    cyc(4);
  endtask

  // Divide ratio of a prescale code
  function automatic int divOf(input int c);
    return (c == 0) ? 1 : (c == 1) ? 8 : (c == 2) ? 64 : 256;
  endfunction

  // One when a count lies within tolerance of the expectation
  function automatic logic [31:0] nearBy(input logic [31:0] got, input int e, input int t);
    if ($isunknown(got)) return 32'h0;
    return (int'(got) >= e - t && int'(got) <= e + t) ? 32'h1 : 32'h0;
  endfunction

  task automatic endTest(input string s);
    $display("test %s done", s);
  endtask

  // Verdict and end of run
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    #400000;
    mismatches++;
    complete_run();
  end

  // Main sequence
  initial begin
    void'($urandom(32'h177ea541));
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    rd(atm_pkg::OFF_CTRL);
    check(rdVal, 32'h0);
    rd(atm_pkg::OFF_PERIOD);
    check(rdVal, 32'h0000_ffff);
    rd(8'h40);
    check({31'h0, errSeen}, 32'h1);
    check(rdVal, 32'h0);
    endTest("reset");
    for (k = 0; k < 9; k++) begin
      v = (k == 0) ? 32'hffff_ffff : $urandom();
      wrr(atm_pkg::OFF_CTRL, v);
      rd(atm_pkg::OFF_CTRL);
      check(rdVal, v & implMask);
    end
    wrr(atm_pkg::OFF_CTRL, 32'h0);
    wrr(atm_pkg::OFF_CTRL_SET, 32'hffff_ffff);
    rd(atm_pkg::OFF_CTRL);
    check(rdVal, implMask);
    wrr(atm_pkg::OFF_CTRL_CLR, ctlOn | ctlGate);
    rd(atm_pkg::OFF_CTRL);
    check(rdVal, implMask & ~(ctlOn | ctlGate));
    wrr(atm_pkg::OFF_CTRL_INV, ctlOn | ctlSrc | 32'h1);
    rd(atm_pkg::OFF_CTRL);
    check(rdVal, implMask & ~(ctlGate | ctlSrc));
    endTest("alias");
    for (k = 0; k < 4; k++) begin
      wrr(atm_pkg::OFF_CTRL, ctlOn | (32'(k) << atm_pkg::B_PS_LO));
      wrr(atm_pkg::OFF_COUNT, 32'h0);
      cyc(divOf(k) * 12);
      rd(atm_pkg::OFF_COUNT);
      check(nearBy(rdVal, 12, 2), 32'h1);
    end
    endTest("prescale");
    wrr(atm_pkg::OFF_CTRL, 32'h0);
    wrr(atm_pkg::OFF_IRQ_STAT, 32'h3);
    wrr(atm_pkg::OFF_PERIOD, 32'h9);
    wrr(atm_pkg::OFF_COUNT, 32'h0);
    wrr(atm_pkg::OFF_IRQ_MASK, 32'h1);
    wrr(atm_pkg::OFF_CTRL, ctlOn);
    cyc(30);
    wrr(atm_pkg::OFF_CTRL, 32'h0);
    rd(atm_pkg::OFF_COUNT);
    check({31'h0, rdVal <= 32'h9}, 32'h1);
    rd(atm_pkg::OFF_IRQ_STAT);
    check(rdVal & 32'h1, 32'h1);
    check({31'h0, timerIrq}, 32'h1);
    wrr(atm_pkg::OFF_IRQ_MASK, 32'h0);
    cyc(1);
    check({31'h0, timerIrq}, 32'h0);
    wrr(atm_pkg::OFF_IRQ_MASK, 32'h1);
    wrr(atm_pkg::OFF_IRQ_STAT, 32'h1);
    cyc(1);
    check({31'h0, timerIrq}, 32'h0);
    endTest("period");
    wrr(atm_pkg::OFF_PERIOD, 32'hffff);
    wrr(atm_pkg::OFF_CTRL, ctlOn | ctlGate);
    wrr(atm_pkg::OFF_COUNT, 32'h0);
    cyc(40);
    rd(atm_pkg::OFF_COUNT);
    check(rdVal, 32'h0);
    gateInput <= 1'b1;
    cyc(40);
    rd(atm_pkg::OFF_COUNT);
    check(nearBy(rdVal, 40, 5), 32'h1);
    gateInput <= 1'b0;
    endTest("gated");
    wrr(atm_pkg::OFF_CTRL, ctlOn | ctlGate | ctlSrc | ctlSync);
    wrr(atm_pkg::OFF_COUNT, 32'h0);
    k = 3 + $urandom_range(9);
    repeat (k) pulse();
    cyc(6);
    rd(atm_pkg::OFF_COUNT);
    check(rdVal, 32'(k));
    wrr(atm_pkg::OFF_CTRL, ctlOn | ctlSrc);
    wrr(atm_pkg::OFF_COUNT, 32'h0);
    cyc(6);
    repeat (k) pulse();
    cyc(6);
    rd(atm_pkg::OFF_COUNT);
    check(rdVal, 32'(k));
    wrr(atm_pkg::OFF_IRQ_STAT, 32'h2);
    wrr(atm_pkg::OFF_COUNT, 32'h55, 1'b1);
    rd(atm_pkg::OFF_CTRL);
    check(rdVal & ctlPend, ctlPend);
    cyc(6);
    rd(atm_pkg::OFF_CTRL);
    check(rdVal & ctlPend, 32'h0);
    rd(atm_pkg::OFF_COUNT);
    check(rdVal, 32'h55);
    rd(atm_pkg::OFF_IRQ_STAT);
    check(rdVal & 32'h2, 32'h2);
    wrr(atm_pkg::OFF_CTRL, ctlOn | ctlSrc | ctlBlk);
    wrr(atm_pkg::OFF_COUNT, 32'h11, 1'b1);
    wrr(atm_pkg::OFF_COUNT, 32'h22);
    cyc(6);
    rd(atm_pkg::OFF_COUNT);
    check(rdVal, 32'h11);
    wrr(atm_pkg::OFF_CTRL, ctlOn | ctlSrc);
    wrr(atm_pkg::OFF_COUNT, 32'h33, 1'b1);
    wrr(atm_pkg::OFF_COUNT, 32'h44);
    cyc(6);
    rd(atm_pkg::OFF_COUNT);
    check(rdVal, 32'h44);
    wrr(atm_pkg::OFF_CTRL, ctlOn | ctlSrc | ctlSync);
    wrr(atm_pkg::OFF_COUNT, 32'h7, 1'b1);
    rd(atm_pkg::OFF_CTRL);
    check(rdVal & ctlPend, 32'h0);
    endTest("external");
    wrr(atm_pkg::OFF_CTRL, ctlOn | ctlIdle);
    wrr(atm_pkg::OFF_MODE, 32'h1 << atm_pkg::B_MODE_IDLE);
    wrr(atm_pkg::OFF_COUNT, 32'h0);
    cyc(20);
    rd(atm_pkg::OFF_COUNT);
    check(rdVal, 32'h0);
    wrr(atm_pkg::OFF_CTRL, ctlOn);
    cyc(20);
    rd(atm_pkg::OFF_COUNT);
    check(nearBy(rdVal, 22, 3), 32'h1);
    wrr(atm_pkg::OFF_MODE, 32'h1 << atm_pkg::B_MODE_SLEEP);
    wrr(atm_pkg::OFF_COUNT, 32'h0);
    cyc(20);
    rd(atm_pkg::OFF_COUNT);
    check(nearBy(rdVal, 22, 3), 32'h1);
    wrr(atm_pkg::OFF_CTRL, 32'h0);
    rd(atm_pkg::OFF_COUNT);
    v = rdVal;
    cyc(20);
    rd(atm_pkg::OFF_COUNT);
    check(rdVal, v);
    endTest("power");
    wrr(atm_pkg::OFF_PERIOD, 32'h5);
    wrr(atm_pkg::OFF_CTRL, ctlOn | ctlBlk);
    rst <= 1'b1;
    cyc(3);
    rst <= 1'b0;
    rd(atm_pkg::OFF_CTRL);
    check(rdVal, 32'h0);
    rd(atm_pkg::OFF_PERIOD);
    check(rdVal, 32'h0000_ffff);
    rd(atm_pkg::OFF_COUNT);
    check(rdVal, 32'h0);
    endTest("mid-run reset");
    complete_run();
  end
endmodule
